// file: hdl/output_efuse_pwm_channel.sv
`timescale 1ns/1ps
`default_nettype none

module output_efuse_pwm_channel (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [9:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  input  wire logic [29:0]         cmd_on_i,
  input  wire logic [29:0][16:0]   current_ma_i,
  input  wire logic [3:0][9:0]     axis_i,
  output logic      [29:0]         drive_o
);

  typedef struct packed {
    logic [4:0]                    pre;
    logic [9:0]                    ms_pre;
    logic                          us_tick;
    logic                          ms_tick;
    logic                          manual;
    logic [29:0]                   man_on;
    logic [15:0]                   common_period;
    logic [29:0][1:0]              lim_sel;
    logic [29:0][17:0]             window_us;
    logic [29:0][13:0]             arm_ms;
    logic [29:0][13:0]             steady_ma;
    logic [29:0][3:0]              retry_max;
    logic [29:0][15:0]             retry_interval;
    efuse_pkg::fuse_state_e [29:0] st;
    logic [29:0][23:0]             elapsed;
    logic [29:0][3:0]              retries;
    logic [29:0][15:0]             wait_ms;
    logic [3:0][3:0]               mode;
    logic [3:0][15:0]              period_us;
    logic [3:0][6:0]               duty;
    logic [3:0][3:0][15:0]         map;
    logic [3:0][19:0]              pwm_cnt;
    logic [3:0][16:0]              peak;
    logic [3:0][16:0]              peak_rep;
    logic [29:0]                   drive;
    logic                          ack;
    logic [31:0]                   rdata;
  } state_s;

  state_s r_reg;
  state_s r_next;

  logic        req;
  logic        wr;
  logic [31:0] bmask;
  logic [31:0] wval;
  logic [31:0] rval;
  logic        in_ch;
  logic        in_mod;
  logic [5:0]  ch_idx;
  logic [1:0]  mod_idx;
  logic [1:0]  sub;
  logic        cmd;
  logic        fault;
  logic [16:0] lim_ma;
  logic [16:0] steady_eff;
  logic [15:0] mval;
  logic [15:0] pu;
  logic [6:0]  du;
  logic [19:0] pc;
  logic [19:0] onc;
  logic        pend;
  logic        is_freq;
  logic        is_duty;
  logic [29:0] gate;

  // Lookup over four breakpoints spaced 256 axis counts apart
  function automatic logic [15:0] map_pick(input logic [3:0][15:0] y, input logic [9:0] x,
                                           input logic [1:0] how);
    logic [1:0]  seg;
    logic [7:0]  fr;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] v;
    seg = x[9:8];
    fr  = x[7:0];
    if (seg == 2'h3) begin
      lo = y[3];
      hi = y[3];
      fr = 8'h00;
    end else begin
      lo = y[seg];
      hi = y[seg + 2'h1];
    end
    unique case (how)
      2'h0: begin
        if (hi >= lo) begin
          v = lo + 16'((24'(hi - lo) * 24'(fr)) >> 8);
        end else begin
          v = lo - 16'((24'(lo - hi) * 24'(fr)) >> 8);
        end
      end
      2'h1: v = lo;
      2'h2: v = (fr == 8'h00) ? lo : hi;
      2'h3: v = (fr < 8'h80) ? lo : hi;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] m);
    return (old & ~m) | (val & m);
  endfunction

  always_comb begin
    r_next = r_reg;
    rval   = 32'h0000_0000;
    wval   = 32'h0000_0000;
    bmask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    req    = cyc_i & stb_i & ~r_reg.ack;
    wr     = req & we_i;
    ch_idx = adr_i[9:4] - efuse_pkg::CH_BASE_HI;
    in_ch  = (adr_i[9:8] != 2'h0) && (ch_idx < 6'(efuse_pkg::NUM_CH));
    in_mod = (adr_i[9:4] >= {2'h0, efuse_pkg::MOD_BASE_HI})
             && (adr_i[9:4] < {2'h0, efuse_pkg::MOD_BASE_HI} + 6'h4);
    mod_idx = adr_i[5:4];
    sub     = adr_i[3:2];

    // Time base: microsecond and millisecond pulses
    r_next.us_tick = (r_reg.pre == 5'(efuse_pkg::US_TICK_CYCLES - 1));
    r_next.pre     = r_next.us_tick ? 5'h00 : r_reg.pre + 5'h01;
    r_next.ms_tick = 1'b0;
    if (r_reg.us_tick) begin
      if (r_reg.ms_pre == 10'(efuse_pkg::MS_TICK_US - 1)) begin
        r_next.ms_pre  = 10'h000;
        r_next.ms_tick = 1'b1;
      end else begin
        r_next.ms_pre = r_reg.ms_pre + 10'h001;
      end
    end

    // Bus access, answered one cycle after the request is seen
    r_next.ack = req;
    if (req) begin
      if (adr_i == efuse_pkg::ADR_CTRL) begin
        rval = {31'h0, r_reg.manual};
        if (wr && sel_i[0]) begin
          r_next.manual = dat_i[0];
          if (dat_i[0] && !r_reg.manual) begin
            r_next.man_on = '0;
          end
        end
      end else if (adr_i == efuse_pkg::ADR_MAN_TGL) begin
        rval = {2'h0, r_reg.man_on};
        if (wr && r_reg.manual) begin
          r_next.man_on = r_reg.man_on ^ (dat_i[29:0] & bmask[29:0]);
        end
      end else if (adr_i == efuse_pkg::ADR_COMMON) begin
        rval = {16'h0, r_reg.common_period};
        wval = merge({16'h0, r_reg.common_period}, dat_i, bmask);
        if (wr) begin
          r_next.common_period = wval[15:0];
        end
      end else if (adr_i == efuse_pkg::ADR_DRIVE) begin
        rval = {2'h0, r_reg.drive};
      end else if (adr_i == efuse_pkg::ADR_CLEAR) begin
        rval = 32'h0000_0000;
      end else if (in_mod) begin
        unique case (sub)
          2'h0: begin
            rval = {28'h0, r_reg.mode[mod_idx]};
            wval = merge({28'h0, r_reg.mode[mod_idx]}, dat_i, bmask);
            // no frequency modes on one, two
            if (wr && wval[3:0] <= efuse_pkg::MODE_FREQ_NEAR
                && !(mod_idx < 2'h2 && wval[3:0] >= efuse_pkg::MODE_FREQ_INTRP)) begin
              r_next.mode[mod_idx] = wval[3:0];
            end
          end
          2'h1: begin
            rval = {9'h0, r_reg.duty[mod_idx], r_reg.period_us[mod_idx]};
            wval = merge(rval, dat_i, bmask);
            if (wr) begin
              r_next.period_us[mod_idx] = wval[15:0];
              r_next.duty[mod_idx] = (wval[22:16] < efuse_pkg::DUTY_MIN) ? efuse_pkg::DUTY_MIN :
                                     (wval[22:16] > efuse_pkg::DUTY_MAX) ? efuse_pkg::DUTY_MAX :
                                     wval[22:16];
            end
          end
          2'h2: begin
            rval = {r_reg.map[mod_idx][1], r_reg.map[mod_idx][0]};
            wval = merge(rval, dat_i, bmask);
            if (wr) begin
              r_next.map[mod_idx][0] = wval[15:0];
              r_next.map[mod_idx][1] = wval[31:16];
            end
          end
          2'h3: begin
            rval = {r_reg.map[mod_idx][3], r_reg.map[mod_idx][2]};
            wval = merge(rval, dat_i, bmask);
            if (wr) begin
              r_next.map[mod_idx][2] = wval[15:0];
              r_next.map[mod_idx][3] = wval[31:16];
            end
          end
        endcase
      end else if (in_ch) begin
        unique case (sub)
          2'h0: begin
            rval = {6'h0, r_reg.lim_sel[ch_idx], 6'h0, r_reg.window_us[ch_idx]};
            wval = merge(rval, dat_i, bmask);
            if (wr) begin
              r_next.lim_sel[ch_idx] = (wval[25:24] == 2'h3) ? 2'h2 : wval[25:24];
              r_next.window_us[ch_idx] =
                (wval[17:0] < efuse_pkg::WINDOW_MIN_US) ? efuse_pkg::WINDOW_MIN_US :
                (wval[17:0] > efuse_pkg::WINDOW_MAX_US) ? efuse_pkg::WINDOW_MAX_US :
                wval[17:0];
            end
          end
          2'h1: begin
            rval = {2'h0, r_reg.steady_ma[ch_idx], 2'h0, r_reg.arm_ms[ch_idx]};
            wval = merge(rval, dat_i, bmask);
            if (wr) begin
              r_next.arm_ms[ch_idx] = (wval[13:0] > efuse_pkg::ARM_MAX_MS) ?
                                      efuse_pkg::ARM_MAX_MS : wval[13:0];
              r_next.steady_ma[ch_idx] = (wval[29:16] > efuse_pkg::STEADY_MAX_MA) ?
                                         efuse_pkg::STEADY_MAX_MA : wval[29:16];
            end
          end
          2'h2: begin
            rval = {r_reg.retry_interval[ch_idx], 12'h0, r_reg.retry_max[ch_idx]};
            wval = merge(rval, dat_i, bmask);
            if (wr) begin
              r_next.retry_max[ch_idx] = wval[3:0];
              r_next.retry_interval[ch_idx]  = wval[31:16];
            end
          end
          2'h3: begin
            rval[16:0] = current_ma_i[ch_idx];
            if (ch_idx >= 6'(efuse_pkg::NUM_PLAIN)) begin
              rval[16:0] = r_reg.peak_rep[2'(ch_idx - 6'(efuse_pkg::NUM_PLAIN))];
            end
            rval[23:20] = r_reg.retries[ch_idx];
            rval[27:24] = r_reg.st[ch_idx];
          end
        endcase
      end
      r_next.rdata = we_i ? 32'h0000_0000 : rval;
    end

    // Modulation generators
    gate = '1;
    for (int m = 0; m < efuse_pkg::NUM_MOD; m++) begin
      is_duty = (r_reg.mode[m] >= efuse_pkg::MODE_DUTY_INTRP)
                && (r_reg.mode[m] <= efuse_pkg::MODE_DUTY_NEAR);
      is_freq = (r_reg.mode[m] >= efuse_pkg::MODE_FREQ_INTRP)
                && (r_reg.mode[m] <= efuse_pkg::MODE_FREQ_NEAR);
      mval = map_pick(r_reg.map[m], axis_i[m],
                      is_freq ? 2'(r_reg.mode[m] - efuse_pkg::MODE_FREQ_INTRP)
                              : 2'(r_reg.mode[m] - efuse_pkg::MODE_DUTY_INTRP));
      pu = is_freq ? mval : (m < 2) ? r_reg.common_period : r_reg.period_us[m];
      pu = (pu < efuse_pkg::PERIOD_MIN_US) ? efuse_pkg::PERIOD_MIN_US :
           (pu > efuse_pkg::PERIOD_MAX_US) ? efuse_pkg::PERIOD_MAX_US : pu;
      du = r_reg.duty[m];
      if (is_duty) begin
        du = (mval > 16'(efuse_pkg::DUTY_FULL)) ? efuse_pkg::DUTY_FULL : mval[6:0];
      end
      pc  = 20'(21'(pu) * 21'(efuse_pkg::US_TICK_CYCLES));
      onc = 20'((27'(pc) * 27'(du)) / 27'(efuse_pkg::DUTY_FULL));
      pend = (r_reg.pwm_cnt[m] >= pc - 20'h00001);
      r_next.pwm_cnt[m] = pend ? 20'h00000 : r_reg.pwm_cnt[m] + 20'h00001;
      // none off, plain switch full on
      unique case (1'b1)
        r_reg.mode[m] == efuse_pkg::MODE_NONE: gate[efuse_pkg::NUM_PLAIN + m] = 1'b0;
        r_reg.mode[m] == efuse_pkg::MODE_DIG:  gate[efuse_pkg::NUM_PLAIN + m] = 1'b1;
        default: gate[efuse_pkg::NUM_PLAIN + m] = (r_reg.pwm_cnt[m] < onc);
      endcase
      if (r_reg.drive[efuse_pkg::NUM_PLAIN + m]
          && current_ma_i[efuse_pkg::NUM_PLAIN + m] > r_reg.peak[m]) begin
        r_next.peak[m] = current_ma_i[efuse_pkg::NUM_PLAIN + m];
      end
      if (pend) begin
        r_next.peak_rep[m] = r_next.peak[m];
        r_next.peak[m]     = 17'h00000;
      end
    end

    // Electronic fuse, one engine per channel
    // 26 plain plus 4 modulated
    for (int c = 0; c < efuse_pkg::NUM_CH; c++) begin
      cmd = r_reg.manual ? r_reg.man_on[c] : cmd_on_i[c];
      unique case (r_reg.lim_sel[c])
        2'h0:    lim_ma = efuse_pkg::LIMIT_7A5_MA;
        2'h1:    lim_ma = efuse_pkg::LIMIT_10A_MA;
        default: lim_ma = efuse_pkg::LIMIT_12A5_MA;
      endcase
      // keep steady level under the limit
      steady_eff = (17'(r_reg.steady_ma[c]) < lim_ma) ? 17'(r_reg.steady_ma[c])
                                                      : lim_ma - 17'h00001;
      fault = (r_reg.elapsed[c] > 24'(efuse_pkg::INRUSH_BLANK_US))
              && (current_ma_i[c] >= efuse_pkg::INRUSH_CEILING_MA);
      if (r_reg.elapsed[c] > 24'(r_reg.window_us[c]) && current_ma_i[c] >= lim_ma) begin
        fault = 1'b1;
      end
      if (r_reg.elapsed[c] > 24'(r_reg.arm_ms[c]) * 24'(efuse_pkg::MS_TICK_US)
          && current_ma_i[c] > steady_eff) begin
        fault = 1'b1;
      end
      unique case (r_reg.st[c])
        efuse_pkg::FS_OFF: begin
          r_next.retries[c] = 4'h0;
          if (cmd) begin
            r_next.st[c]      = efuse_pkg::FS_ON;
            r_next.elapsed[c] = 24'h000000;
          end
        end
        efuse_pkg::FS_ON: begin
          if (!cmd) begin
            r_next.st[c] = efuse_pkg::FS_OFF;
          end else if (fault) begin
            r_next.wait_ms[c] = 16'h0000;
            if (r_reg.retries[c] < r_reg.retry_max[c]) begin
              r_next.st[c]      = efuse_pkg::FS_WAIT;
              r_next.retries[c] = r_reg.retries[c] + 4'h1;
            end else begin
              r_next.st[c] = efuse_pkg::FS_LOCK;
            end
          end else if (r_reg.us_tick && r_reg.elapsed[c] != 24'hFFFFFF) begin
            r_next.elapsed[c] = r_reg.elapsed[c] + 24'h000001;
          end
        end
        efuse_pkg::FS_WAIT: begin
          if (!cmd) begin
            r_next.st[c] = efuse_pkg::FS_OFF;
          end else if (r_reg.wait_ms[c] >= r_reg.retry_interval[c]) begin
            r_next.st[c]      = efuse_pkg::FS_ON;
            r_next.elapsed[c] = 24'h000000;
          end else if (r_reg.ms_tick) begin
            r_next.wait_ms[c] = r_reg.wait_ms[c] + 16'h0001;
          end
        end
        efuse_pkg::FS_LOCK: begin
          // held off until recommanded or cleared
          if (!cmd || (wr && adr_i == efuse_pkg::ADR_CLEAR && dat_i[c] && bmask[c])) begin
            r_next.st[c] = efuse_pkg::FS_OFF;
          end
        end
        default: r_next.st[c] = efuse_pkg::FS_OFF;
      endcase
      r_next.drive[c] = (r_next.st[c] == efuse_pkg::FS_ON) && gate[c];
    end

    // Synchronous reset; configuration returns to safe defaults
    if (rst_i) begin
      r_next = '0;
      r_next.common_period = efuse_pkg::PERIOD_RST_US;
      for (int c = 0; c < efuse_pkg::NUM_CH; c++) begin
        r_next.st[c]        = efuse_pkg::FS_OFF;
        r_next.window_us[c] = efuse_pkg::WINDOW_RST_US;
        r_next.arm_ms[c]    = efuse_pkg::ARM_RST_MS;
        r_next.steady_ma[c] = efuse_pkg::STEADY_RST_MA;
        r_next.retry_max[c] = efuse_pkg::RETRY_RST;
        r_next.retry_interval[c]  = efuse_pkg::RETRY_INTERVAL_RST;
      end
      for (int m = 0; m < efuse_pkg::NUM_MOD; m++) begin
        r_next.period_us[m] = efuse_pkg::PERIOD_RST_US;
        r_next.duty[m]      = efuse_pkg::DUTY_RST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  assign dat_o   = r_reg.rdata;
  assign ack_o   = r_reg.ack;
  assign drive_o = r_reg.drive;

endmodule

`default_nettype wire

// file: pkg/efuse_pkg.sv
package efuse_pkg;

  localparam int NUM_CH    = 30;
  localparam int NUM_PLAIN = 26;
  localparam int NUM_MOD   = 4;

  localparam int CLK_HZ         = 25_000_000;
  localparam int US_PER_SEC     = 1_000_000;
  localparam int US_TICK_CYCLES = CLK_HZ / US_PER_SEC;
  localparam int MS_TICK_US     = 1000;

  localparam int INRUSH_BLANK_US = 20;
  localparam logic [16:0] INRUSH_CEILING_MA = 17'h124F8;
  localparam logic [16:0] LIMIT_7A5_MA  = 17'h01D4C;
  localparam logic [16:0] LIMIT_10A_MA  = 17'h02710;
  localparam logic [16:0] LIMIT_12A5_MA = 17'h030D4;
  localparam logic [13:0] STEADY_MAX_MA = 14'h32C8;
  localparam logic [13:0] ARM_MAX_MS    = 14'h2710;
  localparam logic [17:0] WINDOW_MIN_US = 18'h00096;
  localparam logic [17:0] WINDOW_MAX_US = 18'h25D78;
  localparam logic [15:0] PERIOD_MIN_US = 16'h0028;
  localparam logic [15:0] PERIOD_MAX_US = 16'h8235;
  localparam logic [6:0]  DUTY_FULL     = 7'h64;
  localparam logic [6:0]  DUTY_MIN      = 7'h05;
  localparam logic [6:0]  DUTY_MAX      = 7'h63;

  localparam logic [17:0] WINDOW_RST_US = 18'h00096;
  localparam logic [13:0] ARM_RST_MS    = 14'h01F4;
  localparam logic [13:0] STEADY_RST_MA = 14'h1388;
  localparam logic [3:0]  RETRY_RST     = 4'h3;
  localparam logic [15:0] RETRY_INTERVAL_RST  = 16'h012C;
  localparam logic [15:0] PERIOD_RST_US = 16'h03E8;
  localparam logic [6:0]  DUTY_RST      = 7'h32;

  localparam logic [9:0] ADR_CTRL     = 10'h000;
  localparam logic [9:0] ADR_MAN_TGL  = 10'h004;
  localparam logic [9:0] ADR_CLEAR    = 10'h008;
  localparam logic [9:0] ADR_COMMON   = 10'h00C;
  localparam logic [9:0] ADR_DRIVE    = 10'h010;
  localparam logic [3:0] MOD_BASE_HI  = 4'h4;
  localparam logic [5:0] CH_BASE_HI   = 6'h10;

  localparam logic [3:0] MODE_NONE       = 4'h0;
  localparam logic [3:0] MODE_DIG        = 4'h1;
  localparam logic [3:0] MODE_DUTY_INTRP = 4'h2;
  localparam logic [3:0] MODE_DUTY_NEAR  = 4'h5;
  localparam logic [3:0] MODE_FREQ_INTRP = 4'h6;
  localparam logic [3:0] MODE_FREQ_NEAR  = 4'h9;

  typedef enum logic [3:0] {
    FS_OFF  = 4'b0001,
    FS_ON   = 4'b0010,
    FS_WAIT = 4'b0100,
    FS_LOCK = 4'b1000
  } fuse_state_e;

endpackage

// file: tb/load_model.sv
`timescale 1ns/1ps
`default_nettype none
module load_model (
  input  wire logic              clk_i,
  input  wire logic [29:0]       drive_i,
  input  wire logic [29:0]       short_i,
  input  wire logic [29:0]       heavy_i,
  output logic      [29:0][16:0] current_ma_o
);
  logic [29:0][3:0]  age = '0;
  logic [29:0][16:0] cur = '0;
  assign current_ma_o = cur;
  always @(posedge clk_i) begin
    for (int c = 0; c < 30; c++) begin
      age[c] <= !drive_i[c] ? 4'h0 : (age[c] == 4'hF ? age[c] : age[c] + 4'h1);
      if (!drive_i[c])
        cur[c] <= 17'h00000;
      else if (short_i[c] || (c < 26 && age[c] < 4'h8))
        cur[c] <= 17'h13880;
      else
        cur[c] <= heavy_i[c] ? 17'h02328 : 17'h003E8;
    end
  end
endmodule
`default_nettype wire

// file: tb/efuse_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module efuse_asserts (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [9:0]        adr_i,
  input  wire logic [31:0]       dat_o,
  input  wire logic              ack_o,
  input  wire logic [29:0][16:0] current_ma_i,
  input  wire logic [29:0]       drive_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [9:0] on_cnt;
  wire        req = cyc_i && stb_i && !ack_o;
  // Saturates so a long on-time never wraps back into the blanking span
  always_ff @(posedge clk_i) begin
    if (rst_i || !drive_o[0])
      on_cnt <= 10'h000;
    else if (on_cnt != 10'h3FF)
      on_cnt <= on_cnt + 10'h001;
  end
  ack_after_req_a: assert property (req |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(req))
    else $error("ack without request");
  dat_hold_a: assert property (!req |=> $stable(dat_o))
    else $error("read data changed without request");
  write_zero_a: assert property (ack_o && $past(we_i) |-> dat_o == 32'h0)
    else $error("write answer not zero");
  unmapped_zero_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 10'h3FC
    |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  ceiling_trip_a: assert property (drive_o[0] && on_cnt > 10'd600 &&
    current_ma_i[0] >= efuse_pkg::INRUSH_CEILING_MA |-> ##[1:2] !drive_o[0])
    else $error("ceiling excess did not switch off");
  reset_off_a: assert property (disable iff (1'b0) rst_i |=> drive_o == 30'h0 && !ack_o)
    else $error("outputs active after reset");
  cover property (ack_o && $past(we_i));
  cover property (drive_o[0] && on_cnt > 10'd600);
  cover property ($fell(drive_o[0]));
endmodule
bind output_efuse_pwm_channel efuse_asserts i_efuse_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .current_ma_i(current_ma_i), .drive_o(drive_o));
`default_nettype wire

// file: tb/output_efuse_pwm_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_efuse_pwm_channel_tb_top;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc_i = 1'b0;
  logic              stb_i = 1'b0;
  logic              we_i = 1'b0;
  logic [9:0]        adr_i = 10'h000;
  logic [3:0]        sel_i = 4'hF;
  logic [31:0]       dat_i = 32'h0;
  logic [31:0]       dat_o;
  logic              ack_o;
  logic [29:0]       cmd_on_i = 30'h0;
  logic [29:0][16:0] current_ma_i;
  logic [3:0][9:0]   axis_i = {10'h000, 10'h100, 10'h180, 10'h3FF};
  logic [29:0]       drive_o;
  logic [29:0]       short_i = 30'h0;
  logic [29:0]       heavy_i = 30'h0;
  logic [31:0]       rdat;
  int                mismatches = 0;
  int                tests_run = 0;
  int                cnt;
  logic              prev;
  output_efuse_pwm_channel i_output_efuse_pwm_channel (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cmd_on_i(cmd_on_i), .current_ma_i(current_ma_i),
    .axis_i(axis_i), .drive_o(drive_o));
  load_model i_load_model (.clk_i(clk_i), .drive_i(drive_o), .short_i(short_i),
    .heavy_i(heavy_i), .current_ma_o(current_ma_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads just after an edge see what that edge sampled, before the design updates
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // On-cycles of the second modulated channel over four settled periods
  task automatic high_cnt();
    tick(1000);
    cnt = 0;
    repeat (4000) begin
      @(posedge clk_i);
      cnt += int'(drive_o[27]);
    end
  endtask
  // Tests need about 45000 cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
  initial begin
    tick(6);
    rst_i <= 1'b0;
    rc(10'h100, 32'h00000096);
    rc(10'h104, 32'h138801F4);
    rc(10'h108, 32'h012C0003);
    bus(1'b1, 10'h114, 32'h3FFF3FFF);
    rc(10'h114, 32'h32C82710);
    bus(1'b1, 10'h110, 32'h03000000);
    rc(10'h110, 32'h02000096);
    bus(1'b1, 10'h3FC, 32'hFFFFFFFF);
    rc(10'h3FC, 32'h00000000);
    bus(1'b1, 10'h108, 32'h00000001);
    cmd_on_i[0] <= 1'b1;
    tick(3);
    chk(drive_o[0], 32'h1);
    tick(20);
    chk(drive_o[0], 32'h1);
    tick(700);
    rc(10'h10C, 32'h020003E8);
    short_i[0] <= 1'b1;
    tick(3);
    chk(drive_o[0], 32'h0);
    cnt = 0;
    prev = 1'b0;
    repeat (3000) begin
      @(posedge clk_i);
      if (drive_o[0] && !prev)
        cnt++;
      prev = drive_o[0];
    end
    chk(cnt, 32'd1);
    bus(1'b0, 10'h10C, 32'h0);
    chk(rdat[27:20], 32'h81);
    short_i[0] <= 1'b0;
    tick(20);
    chk(drive_o[0], 32'h0);
    bus(1'b1, efuse_pkg::ADR_CLEAR, 32'h1);
    tick(6);
    chk(drive_o[0], 32'h1);
    // Arming of one millisecond is kept longer than the window
    bus(1'b1, 10'h124, 32'h01F40001);
    bus(1'b1, 10'h128, 32'h0);
    bus(1'b1, 10'h140, 32'h02000096);
    heavy_i <= 30'h18;
    cmd_on_i[4:2] <= 3'h7;
    tick(3000);
    chk(drive_o[4:2], 32'h7);
    tick(1000);
    chk(drive_o[4:2], 32'h5);
    tick(20000);
    chk(drive_o[4:2], 32'h5);
    tick(2000);
    chk(drive_o[4:2], 32'h4);
    rc(10'h13C, 32'h04100000);
    bus(1'b1, efuse_pkg::ADR_CTRL, 32'h1);
    tick(3);
    chk(drive_o, 32'h0);
    bus(1'b1, efuse_pkg::ADR_MAN_TGL, 32'h20);
    tick(3);
    chk(drive_o, 32'h20);
    rc(efuse_pkg::ADR_MAN_TGL, 32'h20);
    bus(1'b1, efuse_pkg::ADR_MAN_TGL, 32'h20);
    tick(3);
    chk(drive_o, 32'h0);
    bus(1'b1, efuse_pkg::ADR_CTRL, 32'h0);
    cmd_on_i[27:26] <= 2'h3;
    tick(10);
    chk(drive_o[27:26], 32'h0);
    bus(1'b1, 10'h040, 32'h1);
    tick(3);
    chk(drive_o[26], 32'h1);
    bus(1'b1, 10'h040, 32'h6);
    rc(10'h040, 32'h1);
    bus(1'b1, 10'h060, 32'h6);
    rc(10'h060, 32'h6);
    // One shared period for the first two modulated channels
    bus(1'b1, efuse_pkg::ADR_COMMON, 32'h1);
    // Axis sits halfway between breakpoints of 40 and 60 percent
    bus(1'b1, 10'h058, 32'h00280014);
    bus(1'b1, 10'h05C, 32'h0050003C);
    bus(1'b1, 10'h050, 32'h2);
    high_cnt();
    chk((cnt + 25) / 50, 32'd40);
    bus(1'b1, 10'h050, 32'h3);
    high_cnt();
    chk((cnt + 25) / 50, 32'd32);
    bus(1'b1, 10'h050, 32'h4);
    high_cnt();
    chk((cnt + 25) / 50, 32'd48);
    bus(1'b0, 10'h2BC, 32'h0);
    chk(rdat[16:0], 32'h003E8);
    end_sim();
  end
endmodule
`default_nettype wire
